// *** core/usb_fiu_params.svh ***
`ifndef USB_FIU_PARAMS_SVH
`define USB_FIU_PARAMS_SVH
// Register offsets
`define OFF_CTRL 4'h0
`define OFF_ADDR 4'h1
`define OFF_INDEX 4'h2
`define OFF_STATUS 4'h3
`define OFF_CONFIG 4'h4
`define OFF_DATA 4'h5
`define OFF_CNT_LO 4'h6
`define OFF_CNT_HI 4'h7
`define OFF_FIFO_RST 4'h8
// Control register bits
`define CTRL_EN_BIT 7
`define CTRL_ADDR_OK_BIT 1
`define CTRL_CONF_BIT 0
// Device address register bits
`define ADDR_FEN_BIT 7
// Endpoint configuration bits
`define CFG_ON_BIT 7
`define CFG_TGL_BIT 3
`define CFG_DIR_BIT 2
// Endpoint status bits
`define STA_BANK_BIT 7
`define STA_INRDY_BIT 4
`define STA_OUTF_BIT 1
`define STA_TXC_BIT 0
// Reset values
`define CFG_RESET 8'h00
`define CFG_EP0 8'h80
`define DEV_ADDR_RESET 7'h00
`endif

// *** core/usb_fiu_pkg.sv ***
package usb_fiu_pkg;
   // Transfer type field encoding
   typedef enum logic [1:0] {
      XT_CONTROL = 2'h0,
      XT_ISO = 2'h1,
      XT_BULK = 2'h2,
      XT_INTR = 2'h3
   } xfer_type_t;
   // Packet sequencer states
   typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX, ST_ACK} seq_state_t;
endpackage : usb_fiu_pkg

// *** core/usb_function_interface.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "usb_fiu_params.svh"
// How it works
// - No token is served until software sets the controller enable bit.
// - With function enable set and no address valid, only address 0 answers.
// - With address valid set, only the programmed device address answers.
// - Status, config, data and count registers follow the endpoint index.
// - A disabled endpoint gives no answer at all.
// - Endpoint 0 is always enabled and always control type.
// - Type field: 00 control, 01 isochronous, 10 bulk, 11 interrupt.
// - Ping-pong endpoints hold control type only from reset; writes of control become bulk.
// - Direction bit 1 is IN, 0 is OUT; ignored for control.
// - Config bit 7 enable, bit 2 direction, bits 1:0 type.
// - FIFO reset clears pointer, byte count and data toggle.
// - Bit n of the reset register holds endpoint n in reset.
// - FIFO reset leaves the ping-pong bank untouched.
// - A valid packet is stored and its byte count loaded.
// - Reading the FIFO never changes the byte count.
// - Each data port read steps the selected pointer, which holds once it reaches DEPTH.
// - Each data port write with the pointer below DEPTH stores a byte and steps the pointer only.
// - Token identity and address checking happen here; the rest upstream.
// - While the receive flag is set, OUT tokens get NAK.
// - While IN ready is clear, IN tokens get NAK.
module usb_function_interface
   import usb_fiu_pkg::*;
#(
   parameter int NUM_EP = 7,
   parameter int DEPTH = 32,
   parameter int PP_FIRST = 4
)
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Serial engine, decoded packets
   input wire logic bus_reset,
   input wire logic tok_valid,
   input wire logic tok_in,
   input wire logic [6:0] tok_addr,
   input wire logic [3:0] tok_ep,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_done,
   input wire logic tx_take,
   input wire logic host_ack,
   output logic hs_ack,
   output logic hs_nak,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_last,
   // Status levels
   output logic controller_on,
   output logic configured
);

   localparam int EW = $clog2(NUM_EP);
   localparam int AW = $clog2(DEPTH) + 1;
   localparam int CW = 11;
   localparam logic [AW-1:0] FULL = AW'(DEPTH);

   // Storage and per-endpoint state
   logic [7:0] mem_q [NUM_EP*DEPTH];
   logic [7:0] cfg_q [NUM_EP];
   logic [AW-1:0] ptr_q [NUM_EP];
   logic [CW-1:0] cnt_q [NUM_EP];
   logic [NUM_EP-1:0] tgl_q, outf_q, inrdy_q, txc_q, bank_q;
   logic [7:0] cfg_eff [NUM_EP];
   // Global registers
   logic ctrl_en_q, adr_ok_q, conf_q, fen_q;
   logic [6:0] dev_addr_q;
   logic [3:0] idx_q;
   logic [7:0] rst_q, rdata_q, rd_mux;
   // Sequencer
   seq_state_t st_q;
   logic [EW-1:0] cur_q;
   logic [CW-1:0] rxn_q;
   logic [AW-1:0] txi_q;
   logic hs_ack_q, hs_nak_q, tx_valid_q, tx_last_q;
   logic [7:0] tx_data_q;

   // Flat storage index of one endpoint byte
   function automatic int unsigned midx(input logic [EW-1:0] e, input logic [AW-1:0] p);
      return int'(e) * DEPTH + int'(p[AW-2:0]);
   endfunction : midx

   // Stored config; toggle bit is hardware owned
   function automatic logic [7:0] cfg_fix(input int e, input logic [7:0] w);
      logic [7:0] c;
      c = {w[`CFG_ON_BIT], 4'h0, w[`CFG_DIR_BIT], w[1:0]};
      if (e >= PP_FIRST && w[1:0] == XT_CONTROL)
         c[1:0] = XT_BULK;
      return c;
   endfunction : cfg_fix

   // Effective configuration per endpoint
   always_comb
   begin
      for (int e = 0; e < NUM_EP; e++)
      begin
         cfg_eff[e] = (e == 0) ? `CFG_EP0 : cfg_q[e];
         cfg_eff[e][`CFG_TGL_BIT] = tgl_q[e];
      end
   end

   // Token decode
   wire logic [EW-1:0] tep = tok_ep[EW-1:0];
   wire logic tep_ok = int'(tok_ep) < NUM_EP;
   wire logic [7:0] tcfg = tep_ok ? cfg_eff[tep] : 8'h00;
   wire logic addr_ok = adr_ok_q ? (tok_addr == dev_addr_q) : (tok_addr == `DEV_ADDR_RESET);
   wire logic tok_hit = tok_valid && ctrl_en_q && fen_q && addr_ok && tep_ok &&
                        tcfg[`CFG_ON_BIT] && !rst_q[tep] && st_q == ST_IDLE;
   wire logic t_ctl = tcfg[1:0] == XT_CONTROL;
   wire logic dir_ok = t_ctl || (tcfg[`CFG_DIR_BIT] == tok_in);
   wire logic out_go = tok_hit && dir_ok && !tok_in;
   wire logic in_go = tok_hit && dir_ok && tok_in;
   wire logic take_out = out_go && !outf_q[tep];
   wire logic nak_out = out_go && outf_q[tep];
   wire logic take_in = in_go && inrdy_q[tep];
   wire logic nak_in = in_go && !inrdy_q[tep];
   wire logic rx_fin = st_q == ST_RX && rx_done;
   wire logic tx_fin = st_q == ST_ACK && host_ack;
   wire logic [AW-1:0] cur_len = ptr_q[cur_q];
   wire logic [AW-1:0] in_len = ptr_q[tep];
   wire logic [AW-1:0] txi_nx = AW'(txi_q + AW'(1));
   wire logic [CW-1:0] cur_cnt = cnt_q[cur_q];

   // Register decode
   // endpoint index selects
   wire logic [EW-1:0] sel = idx_q[EW-1:0];
   wire logic sel_ok = int'(idx_q) < NUM_EP;
   wire logic wr_ctrl = reg_wr && reg_addr == `OFF_CTRL;
   wire logic wr_addr = reg_wr && reg_addr == `OFF_ADDR;
   wire logic wr_idx = reg_wr && reg_addr == `OFF_INDEX;
   wire logic wr_stat = reg_wr && reg_addr == `OFF_STATUS && sel_ok;
   wire logic wr_cfg = reg_wr && reg_addr == `OFF_CONFIG && sel_ok;
   wire logic wr_dat = reg_wr && reg_addr == `OFF_DATA && sel_ok;
   wire logic wr_rst = reg_wr && reg_addr == `OFF_FIFO_RST;
   wire logic rd_dat = reg_rd && reg_addr == `OFF_DATA && sel_ok;
   wire logic [AW-1:0] sel_ptr = ptr_q[sel];
   wire logic [CW-1:0] sel_cnt = cnt_q[sel];
   wire logic [7:0] stat_rd = {bank_q[sel], 2'h0, inrdy_q[sel], 2'h0, outf_q[sel], txc_q[sel]};
   wire logic [7:0] ctrl_rd = {ctrl_en_q, 5'h00, adr_ok_q, conf_q};

   // Read data select; per-endpoint registers read zero when out of range
   always_comb
   begin
      rd_mux = 8'h00;
      unique case (reg_addr)
         `OFF_CTRL: rd_mux = ctrl_rd;
         `OFF_ADDR: rd_mux = {fen_q, dev_addr_q};
         `OFF_INDEX: rd_mux = {4'h0, idx_q};
         `OFF_STATUS: rd_mux = sel_ok ? stat_rd : 8'h00;
         `OFF_CONFIG: rd_mux = sel_ok ? cfg_eff[sel] : 8'h00;
         `OFF_DATA: rd_mux = sel_ok ? mem_q[midx(sel, sel_ptr)] : 8'h00;
         `OFF_CNT_LO: rd_mux = sel_ok ? sel_cnt[7:0] : 8'h00;
         `OFF_CNT_HI: rd_mux = sel_ok ? {5'h00, sel_cnt[CW-1:8]} : 8'h00;
         `OFF_FIFO_RST: rd_mux = rst_q;
         default: rd_mux = 8'h00;
      endcase
   end

   // Global registers; bus reset drops the address back to 0
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ctrl_en_q <= 1'b0;
         adr_ok_q <= 1'b0;
         conf_q <= 1'b0;
         fen_q <= 1'b0;
         dev_addr_q <= `DEV_ADDR_RESET;
         idx_q <= 4'h0;
         rst_q <= 8'h00;
         rdata_q <= 8'h00;
      end
      else if (ce)
      begin
         rdata_q <= reg_rd ? rd_mux : 8'h00;
         if (wr_ctrl)
         begin
            ctrl_en_q <= reg_wdata[`CTRL_EN_BIT];
            adr_ok_q <= reg_wdata[`CTRL_ADDR_OK_BIT];
            conf_q <= reg_wdata[`CTRL_CONF_BIT];
         end
         if (wr_addr)
         begin
            fen_q <= reg_wdata[`ADDR_FEN_BIT];
            dev_addr_q <= reg_wdata[6:0];
         end
         if (wr_idx)
            idx_q <= reg_wdata[3:0];
         if (wr_rst)
            rst_q <= reg_wdata;
         if (bus_reset)
         begin
            fen_q <= 1'b0;
            adr_ok_q <= 1'b0;
            conf_q <= 1'b0;
            dev_addr_q <= `DEV_ADDR_RESET;
         end
      end
   end

   // Packet sequencer; one transaction at a time, tokens ignored while busy
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         st_q <= ST_IDLE;
         cur_q <= '0;
         rxn_q <= '0;
         txi_q <= '0;
         hs_ack_q <= 1'b0;
         hs_nak_q <= 1'b0;
         tx_valid_q <= 1'b0;
         tx_last_q <= 1'b0;
         tx_data_q <= 8'h00;
      end
      else if (ce)
      begin
         hs_ack_q <= 1'b0;
         hs_nak_q <= 1'b0;
         if (!ctrl_en_q || bus_reset)
         begin
            st_q <= ST_IDLE;
            tx_valid_q <= 1'b0;
            tx_last_q <= 1'b0;
         end
         else
         begin
            unique case (st_q)
               ST_IDLE:
               begin
                  hs_nak_q <= nak_out || nak_in;
                  if (take_out)
                  begin
                     st_q <= ST_RX;
                     cur_q <= tep;
                     rxn_q <= '0;
                  end
                  else if (take_in)
                  begin
                     cur_q <= tep;
                     txi_q <= '0;
                     tx_data_q <= mem_q[midx(tep, '0)];
                     tx_valid_q <= in_len != '0;
                     tx_last_q <= in_len <= AW'(1);
                     st_q <= (in_len == '0) ? ST_ACK : ST_TX;
                  end
               end
               ST_RX:
               begin
                  // count each byte, even past capacity; the count saturates at all ones
                  if (rx_done)
                  begin
                     hs_ack_q <= 1'b1;
                     st_q <= ST_IDLE;
                  end
                  else if (rx_valid && rxn_q != '1)
                     rxn_q <= CW'(rxn_q + CW'(1));
               end
               ST_TX:
               begin
                  if (tx_take && tx_last_q)
                  begin
                     tx_valid_q <= 1'b0;
                     tx_last_q <= 1'b0;
                     st_q <= ST_ACK;
                  end
                  else if (tx_take)
                  begin
                     txi_q <= txi_nx;
                     tx_data_q <= mem_q[midx(cur_q, txi_nx)];
                     tx_last_q <= AW'(txi_nx + AW'(1)) == cur_len;
                  end
               end
               ST_ACK:
               begin
                  // Host timeout shows as a new token; packet stays armed
                  tx_last_q <= 1'b0;
                  if (host_ack || tok_valid)
                     st_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // FIFO storage, written by the receiver and by software
   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (st_q == ST_RX && rx_valid && !rx_done && int'(rxn_q) < DEPTH)
            mem_q[midx(cur_q, AW'(rxn_q))] <= rx_data;
         if (wr_dat && sel_ptr != FULL)
            mem_q[midx(sel, sel_ptr)] <= reg_wdata;
      end
   end

   // Per-endpoint state; hardware set lands after software clear
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         for (int e = 0; e < NUM_EP; e++)
         begin
            cfg_q[e] <= `CFG_RESET;
            ptr_q[e] <= '0;
            cnt_q[e] <= '0;
         end
         tgl_q <= '0;
         outf_q <= '0;
         inrdy_q <= '0;
         txc_q <= '0;
         bank_q <= '0;
      end
      else if (ce)
      begin
         for (int e = 0; e < NUM_EP; e++)
         begin
            if (wr_cfg && sel == EW'(e) && e != 0)
               cfg_q[e] <= cfg_fix(e, reg_wdata);
            if (wr_stat && sel == EW'(e))
            begin
               if (!reg_wdata[`STA_TXC_BIT])
                  txc_q[e] <= 1'b0;
               if (!reg_wdata[`STA_OUTF_BIT])
                  outf_q[e] <= 1'b0;
               if (reg_wdata[`STA_INRDY_BIT])
                  inrdy_q[e] <= 1'b1;
               else if (inrdy_q[e])
               begin
                  // Cancel drops the loaded packet
                  inrdy_q[e] <= 1'b0;
                  ptr_q[e] <= '0;
               end
               if (e >= PP_FIRST)
                  bank_q[e] <= bank_q[e] ^
                     ((!reg_wdata[`STA_OUTF_BIT] && outf_q[e]) ^
                      (reg_wdata[`STA_INRDY_BIT] && !inrdy_q[e]));
            end
            if ((rd_dat || wr_dat) && sel == EW'(e) && ptr_q[e] != FULL)
               ptr_q[e] <= AW'(ptr_q[e] + AW'(1));
            if (rx_fin && cur_q == EW'(e))
            begin
               outf_q[e] <= 1'b1;
               cnt_q[e] <= rxn_q;
               ptr_q[e] <= '0;
               tgl_q[e] <= ~tgl_q[e];
            end
            if (tx_fin && cur_q == EW'(e))
            begin
               inrdy_q[e] <= 1'b0;
               txc_q[e] <= 1'b1;
               ptr_q[e] <= '0;
               tgl_q[e] <= ~tgl_q[e];
            end
            if (rst_q[e])
            begin
               ptr_q[e] <= '0;
               cnt_q[e] <= '0;
               tgl_q[e] <= 1'b0;
            end
         end
      end
   end

   // Outputs straight from flops
   assign reg_rdata = rdata_q;
   assign hs_ack = hs_ack_q;
   assign hs_nak = hs_nak_q;
   assign tx_valid = tx_valid_q;
   assign tx_data = tx_data_q;
   assign tx_last = tx_last_q;
   assign controller_on = ctrl_en_q;
   assign configured = conf_q;

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   a_out_nak_busy: assert property (ce && out_go && outf_q[tep] |=> hs_nak_q)
      else $error("OUT with full endpoint not refused");
   a_in_nak_wait: assert property (ce && in_go && !inrdy_q[tep] |=> hs_nak_q && st_q == ST_IDLE)
      else $error("IN without ready not refused");
   a_off_silent: assert property (ce && tok_valid && tep_ok && !tcfg[`CFG_ON_BIT] && st_q == ST_IDLE
      |=> st_q == ST_IDLE && !hs_nak_q && !hs_ack_q)
      else $error("Disabled endpoint answered");
   a_addr_match: assert property (ce && tok_valid && adr_ok_q && tok_addr != dev_addr_q &&
      st_q == ST_IDLE |=> st_q == ST_IDLE && !hs_nak_q)
      else $error("Foreign address answered");
   a_enable_gate: assert property (!ctrl_en_q && $past(ctrl_en_q) == 1'b0
      |-> st_q == ST_IDLE && !tx_valid_q && !hs_ack_q)
      else $error("Activity while controller disabled");
   a_count_kept: assert property (ce && rd_dat && st_q == ST_IDLE && !rst_q[sel]
      |=> sel_cnt == $past(sel_cnt))
      else $error("FIFO read changed byte count");
   a_read_steps: assert property (ce && rd_dat && sel_ptr != FULL && st_q == ST_IDLE && !rst_q[sel]
      |=> sel_ptr == AW'($past(sel_ptr) + AW'(1)))
      else $error("Data read did not step pointer");
   a_fifo_clear: assert property (ce && rst_q[sel] && !reg_wr
      |=> sel_ptr == '0 && sel_cnt == '0 && !tgl_q[sel])
      else $error("FIFO reset incomplete");
   a_ep0_ctrl: assert property (cfg_eff[0][`CFG_ON_BIT] && cfg_eff[0][1:0] == XT_CONTROL)
      else $error("Endpoint 0 not enabled control");
   a_rx_count: assert property (ce && rx_fin && !rst_q[cur_q]
      |=> outf_q[cur_q] && cur_cnt == $past(rxn_q) && hs_ack_q)
      else $error("Received count not loaded");

endmodule : usb_function_interface
`default_nettype wire

// *** bench/usb_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module usb_host_model
(
   // Clock
   input wire logic clk,
   // Toward the function interface
   output logic tok_valid,
   output logic tok_in,
   output logic [6:0] tok_addr,
   output logic [3:0] tok_ep,
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_done,
   output logic tx_take,
   output logic host_ack,
   // From the function interface
   input wire logic hs_ack,
   input wire logic hs_nak,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last
);
   int ack_n = 0;
   int nak_n = 0;
   logic [7:0] got [$];
   // Quiet link at time zero
   initial
   begin
      tok_valid = 1'b0;
      tok_in = 1'b0;
      tok_addr = 7'h00;
      tok_ep = 4'h0;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      rx_done = 1'b0;
      tx_take = 1'b0;
      host_ack = 1'b0;
   end
   // Tally of handshakes, one per pulse
   always @(posedge clk)
   begin
      if (hs_ack === 1'b1)
         ack_n <= ack_n + 1;
      if (hs_nak === 1'b1)
         nak_n <= nak_n + 1;
   end
   task automatic token(input logic i, input logic [6:0] a, input logic [3:0] e);
      @(posedge clk);
      tok_valid <= 1'b1;
      tok_in <= i;
      tok_addr <= a;
      tok_ep <= e;
      @(posedge clk);
      tok_valid <= 1'b0;
      // Released address does not keep its value
      tok_addr <= ~a;
   endtask : token
   // OUT token, n bytes counting up from b, good CRC
   task automatic out_pkt(input logic [6:0] a, input logic [3:0] e, input int n,
                          input logic [7:0] b);
      token(1'b0, a, e);
      for (int k = 0; k < n; k++)
      begin
         @(posedge clk);
         rx_valid <= 1'b1;
         rx_data <= b + 8'(k);
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data <= ~rx_data;
      rx_done <= 1'b1;
      @(posedge clk);
      rx_done <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : out_pkt
   // IN token; take each byte on alternate cycles, then ACK
   task automatic in_pkt(input logic [6:0] a, input logic [3:0] e);
      logic fin;
      fin = 1'b0;
      got.delete();
      token(1'b1, a, e);
      for (int k = 0; k < 40; k++)
      begin
         @(posedge clk);
         if (tx_take)
            tx_take <= 1'b0;
         else if (tx_valid === 1'b1)
         begin
            got.push_back(tx_data);
            fin = tx_last;
            tx_take <= 1'b1;
         end
         else if (fin)
         begin
            host_ack <= 1'b1;
            @(posedge clk);
            host_ack <= 1'b0;
            break;
         end
      end
      repeat (2) @(posedge clk);
   endtask : in_pkt
endmodule : usb_host_model
`default_nettype wire

// *** bench/tb_usb_function_interface.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "usb_fiu_params.svh"
module tb_usb_function_interface;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   logic bus_reset = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] r;
   wire [7:0] reg_rdata, rx_data, tx_data;
   wire [6:0] tok_addr;
   wire [3:0] tok_ep;
   wire tok_valid, tok_in, rx_valid, rx_done, tx_take, host_ack;
   wire hs_ack, hs_nak, tx_valid, tx_last, controller_on, configured;
   int fail_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int a0 = 0;
   int n0 = 0;
   usb_function_interface DUT (.clk(clk), .reset(reset), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .bus_reset(bus_reset), .tok_valid(tok_valid), .tok_in(tok_in), .tok_addr(tok_addr),
      .tok_ep(tok_ep), .rx_valid(rx_valid), .rx_data(rx_data), .rx_done(rx_done),
      .tx_take(tx_take), .host_ack(host_ack), .hs_ack(hs_ack), .hs_nak(hs_nak),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
      .controller_on(controller_on), .configured(configured));
   usb_host_model host (.clk(clk), .tok_valid(tok_valid), .tok_in(tok_in),
      .tok_addr(tok_addr), .tok_ep(tok_ep), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_done(rx_done), .tx_take(tx_take), .host_ack(host_ack), .hs_ack(hs_ack),
      .hs_nak(hs_nak), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last));
   // 25 MHz clock
   always #20 clk = ~clk;
   task automatic final_report();
      $display("Compares %0d, errors %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : final_report
   // Hang guard, well above the expected run length
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 8000)
      begin
         fail_count++;
         final_report();
      end
   end
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   // One-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd
   task automatic rc(input logic [3:0] a, input logic [7:0] exp, input string nm);
      logic [7:0] d;
      rd(a, d);
      check(nm, d, exp);
   endtask : rc
   // Handshakes seen since the previous call
   task automatic hs(input logic [7:0] ea, input logic [7:0] en, input string nm);
      check({nm, " ack"}, 8'(host.ack_n - a0), ea);
      check({nm, " nak"}, 8'(host.nak_n - n0), en);
      a0 = host.ack_n;
      n0 = host.nak_n;
   endtask : hs
   task automatic fifo_rst(input logic [7:0] m);
      wr(`OFF_FIFO_RST, m);
      wr(`OFF_FIFO_RST, 8'h00);
   endtask : fifo_rst
   // Main sequence
   initial
   begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      rc(`OFF_INDEX, 8'h00, "index");
      rc(`OFF_CONFIG, 8'h80, "ep0 cfg");
      wr(`OFF_CONFIG, 8'h06);
      rc(`OFF_CONFIG, 8'h80, "ep0 kept");
      wr(`OFF_INDEX, 8'h01);
      rc(`OFF_INDEX, 8'h01, "index 1");
      rc(`OFF_CONFIG, 8'h00, "ep1 cfg");
      wr(`OFF_INDEX, 8'h00);
      wr(`OFF_ADDR, 8'h80);
      host.out_pkt(7'h00, 4'h0, 2, 8'h10);
      hs(8'h00, 8'h00, "off");
      wr(`OFF_CTRL, 8'h80);
      // Let the write settle past the edge that took it
      #1;
      check("ctl on", {7'h00, controller_on}, 8'h01);
      host.out_pkt(7'h00, 4'h0, 3, 8'hA1);
      hs(8'h01, 8'h00, "addr0");
      rc(`OFF_CNT_LO, 8'h03, "cnt");
      rc(`OFF_DATA, 8'hA1, "d0");
      rc(`OFF_DATA, 8'hA2, "d1");
      rc(`OFF_DATA, 8'hA3, "d2");
      rc(`OFF_CNT_LO, 8'h03, "cnt kept");
      rc(`OFF_CNT_HI, 8'h00, "cnt hi");
      host.out_pkt(7'h00, 4'h0, 1, 8'h55);
      hs(8'h00, 8'h01, "rx busy");
      wr(`OFF_STATUS, 8'h00);
      fifo_rst(8'h01);
      rc(`OFF_CNT_LO, 8'h00, "cnt clr");
      wr(`OFF_ADDR, 8'h85);
      wr(`OFF_CTRL, 8'h83);
      #1;
      check("conf", {7'h00, configured}, 8'h01);
      host.out_pkt(7'h00, 4'h0, 0, 8'h00);
      hs(8'h00, 8'h00, "old addr");
      host.out_pkt(7'h05, 4'h0, 0, 8'h00);
      hs(8'h01, 8'h00, "new addr");
      wr(`OFF_STATUS, 8'h00);
      // bulk IN on endpoint 1, well inside its FIFO
      wr(`OFF_INDEX, 8'h01);
      wr(`OFF_CONFIG, 8'h86);
      wr(`OFF_DATA, 8'h3C);
      wr(`OFF_DATA, 8'hC3);
      rc(`OFF_CNT_LO, 8'h00, "wr cnt");
      host.in_pkt(7'h05, 4'h1);
      hs(8'h00, 8'h01, "in nak");
      host.out_pkt(7'h05, 4'h1, 1, 8'h00);
      hs(8'h00, 8'h00, "dir");
      wr(`OFF_STATUS, 8'h10);
      host.in_pkt(7'h05, 4'h1);
      check("in len", 8'(host.got.size()), 8'h02);
      check("in b0", host.got[0], 8'h3C);
      check("in b1", host.got[1], 8'hC3);
      wr(`OFF_DATA, 8'h11);
      rc(`OFF_CONFIG, 8'h8E, "tgl set");
      fifo_rst(8'h02);
      rc(`OFF_CONFIG, 8'h86, "tgl clr");
      wr(`OFF_DATA, 8'h22);
      wr(`OFF_STATUS, 8'h10);
      host.in_pkt(7'h05, 4'h1);
      check("ptr len", 8'(host.got.size()), 8'h01);
      check("ptr b0", host.got[0], 8'h22);
      // Disabled endpoint, then every type and direction
      wr(`OFF_INDEX, 8'h02);
      host.out_pkt(7'h05, 4'h2, 1, 8'h00);
      hs(8'h00, 8'h00, "ep off");
      for (int t = 0; t < 8; t++)
      begin
         wr(`OFF_CONFIG, 8'h80 | 8'(t));
         rc(`OFF_CONFIG, 8'h80 | 8'(t), "type");
      end
      wr(`OFF_CONFIG, 8'h84);
      host.out_pkt(7'h05, 4'h2, 1, 8'h77);
      hs(8'h01, 8'h00, "ctl dir");
      // Ping-pong endpoint 4
      wr(`OFF_INDEX, 8'h04);
      wr(`OFF_CONFIG, 8'h80);
      rc(`OFF_CONFIG, 8'h82, "pp ctl");
      wr(`OFF_CONFIG, 8'h86);
      wr(`OFF_STATUS, 8'h10);
      rd(`OFF_STATUS, r);
      check("bank", {7'h00, r[`STA_BANK_BIT]}, 8'h01);
      fifo_rst(8'h10);
      rd(`OFF_STATUS, r);
      check("bank kept", {7'h00, r[`STA_BANK_BIT]}, 8'h01);
      // Clock enable low: a write strobe in that cycle is not taken
      @(posedge clk);
      ce <= 1'b0;
      wr(`OFF_INDEX, 8'h03);
      ce <= 1'b1;
      rc(`OFF_INDEX, 8'h04, "ce hold");
      // Bus reset drops function enable, address and configured state
      @(posedge clk);
      bus_reset <= 1'b1;
      @(posedge clk);
      bus_reset <= 1'b0;
      host.out_pkt(7'h05, 4'h0, 0, 8'h00);
      hs(8'h00, 8'h00, "bus rst");
      check("conf clr", {7'h00, configured}, 8'h00);
      wr(`OFF_ADDR, 8'h80);
      host.out_pkt(7'h00, 4'h0, 0, 8'h00);
      hs(8'h01, 8'h00, "addr0 again");
      final_report();
   end
endmodule : tb_usb_function_interface
`default_nettype wire
